// [src/mat_regs.svh]
// Register offsets, field positions, reset values and timing of the MAC table
`ifndef MAT_REGS_SVH
`define MAT_REGS_SVH
`define MAT_CTRL 8'h00
`define MAT_AGE 8'h04
`define MAT_MODE 8'h08
`define MAT_KVLAN 8'h0C
`define MAT_KMACL 8'h10
`define MAT_KMACH 8'h14
`define MAT_KPORT 8'h18
`define MAT_CMD 8'h1C
`define MAT_STAT 8'h20
`define MAT_RVLAN 8'h24
`define MAT_RMACL 8'h28
`define MAT_RMACH 8'h2C
`define MAT_RPORT 8'h30
`define MAT_SCNT 8'h34
`define MAT_CTRL_AGEOFF 0
`define MAT_CTRL_FLUSH 1
`define MAT_CMD_ADD 0
`define MAT_CMD_DEL 1
`define MAT_CMD_NEXT 2
`define MAT_AGE_RST 24'h00012C
`define MAT_AGE_MIN 24'h00000A
`define MAT_AGE_MAX 24'h989680
`define MAT_STAT_MAX 7'h40
`define MAT_TICK_NS 1000000000
`define MAT_CLK_NS 40
`endif

// [src/mat_pkg.sv]
// Types of the MAC address table
package mat_pkg;
  typedef enum logic [1:0] {MAT_AUTO, MAT_NOLRN, MAT_SECURE} mat_lrn_t;
  typedef enum logic [3:0] {ST_IDLE, ST_FRM, ST_FRM_END, ST_AGE, ST_FLUSH,
                            ST_STAT, ST_STAT_END, ST_NEXT, ST_NEXT_END} mat_state_t;
endpackage

// [src/mat_table.sv]
// MAC address table: learning, aging, static entries and ordered lookup
`timescale 1ns/100ps
`default_nettype none
`include "mat_regs.svh"
// How it works
// - Unrefreshed dynamic entries expire, default 300 seconds.
// - Aging can be switched off entirely.
// - Aging time 10 to 10000000 s, reset 300.
// - Auto mode installs unknown sources at once.
// - Disabled learning creates no entries.
// - Secure mode passes static sources only, drops rest.
// - Owning function blocks software mode writes.
// - At most 64 static entries with VLAN, MAC, ports.
// - Entries ordered by VLAN, then MAC.
// - Table of 8192 entries, each static or dynamic.
// - Lookup returns exact match or next one.
// - Past last entry gives end-of-table flag.
// - Flush removes dynamic entries, keeps static ones.
// - Result carries type, VLAN, MAC and ports.
// - Frames go to ports of destination entry.
// - Source hit restarts age of dynamic entry.
module mat_table #(
  parameter int  DEPTH       = 8192,
  parameter int  NPORTS      = 12,
  parameter int  TICK_CYCLES = `MAT_TICK_NS / `MAT_CLK_NS,
  localparam int PW          = $clog2(NPORTS),
  localparam int IW          = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Frame lookup request
  input  wire logic                frm_valid,
  output logic                     frm_ready,
  input  wire logic [PW-1:0]       frm_port,
  input  wire logic [11:0]         frm_vlan,
  input  wire logic [47:0]         frame_source_address,
  input  wire logic [47:0]         frame_destination_address,
  // Forwarding result
  output logic                     fwd_valid,
  output logic                     fwd_hit,
  output logic                     fwd_drop,
  output logic [NPORTS-1:0]        fwd_ports,
  // Learning mode taken over by another function
  input  wire logic [NPORTS-1:0]   auth_own,
  input  wire logic [2*NPORTS-1:0] auth_mode
);
  // Table storage; only the flags need a reset
  logic [DEPTH-1:0]        vld_q;
  logic [DEPTH-1:0]        sta_q;
  logic [11:0]             vlan_m [DEPTH];
  logic [47:0]             mac_m  [DEPTH];
  logic [NPORTS-1:0]       prt_m  [DEPTH];
  logic [23:0]             age_m  [DEPTH];
  // Scan engine
  mat_pkg::mat_state_t     st_q;
  logic [IW-1:0]           idx_q;
  logic [59:0]             key_q;
  logic [59:0]             dkey_q;
  logic [59:0]             bkey_q;
  logic [PW-1:0]           fport_q;
  logic                    m_q, msta_q, d_q, f_q, b_q, bsta_q;
  logic [IW-1:0]           midx_q;
  logic [IW-1:0]           fidx_q;
  logic [NPORTS-1:0]       dprt_q;
  logic [NPORTS-1:0]       bprt_q;
  // Software registers and results
  logic                    ageoff_q;
  logic [23:0]             agetime_q;
  logic [2*NPORTS-1:0]     mode_q;
  logic [11:0]             kvlan_q;
  logic [47:0]             kmac_q;
  logic [NPORTS-1:0]       kport_q;
  logic                    flush_p_q, cmd_p_q, age_p_q;
  logic [2:0]              cmd_q;
  logic                    eot_q, rsta_q, err_q;
  logic [6:0]              scnt_q;
  logic [11:0]             rvlan_q;
  logic [47:0]             rmac_q;
  logic [NPORTS-1:0]       rport_q;
  logic [31:0]             tick_q;
  logic [31:0]             prdata_q;
  logic [31:0]             rdv;
  logic                    fv_q, fh_q, fd_q;
  logic [NPORTS-1:0]       fp_q;
  // Table write port
  logic                    we, wv, ws;
  logic [IW-1:0]           widx;
  logic [11:0]             wvl;
  logic [47:0]             wmc;
  logic [NPORTS-1:0]       wpt;
  logic [23:0]             wag;
  logic [2*NPORTS-1:0]     emode;
  logic [2*NPORTS-1:0]     omask;

  function automatic logic [1:0] mode_of(input logic [2*NPORTS-1:0] m,
                                         input logic [PW-1:0] p);
    mode_of = m[2*p +: 2];
  endfunction

  function automatic logic [NPORTS-1:0] onehot(input logic [PW-1:0] p);
    onehot = NPORTS'(1) << p;
  endfunction

  // Owner's mode overrides the software mode per port
  for (genvar i = 0; i < NPORTS; i++) begin : g_mode
    assign emode[2*i +: 2] = auth_own[i] ? auth_mode[2*i +: 2] : mode_q[2*i +: 2];
    assign omask[2*i +: 2] = {2{auth_own[i]}};
  end

  // Entry under the scan pointer and the comparisons on it
  wire [59:0] cur_key  = {vlan_m[idx_q], mac_m[idx_q]};
  wire        cur_v    = vld_q[idx_q];
  wire        cur_s    = sta_q[idx_q];
  wire [23:0] age_nx   = age_m[idx_q] + 24'h000001;
  wire        last     = idx_q == IW'(DEPTH - 1);
  wire        eq_a     = cur_v && cur_key == key_q;
  wire        eq_d     = cur_v && cur_key == dkey_q;
  wire        better   = cur_v && cur_key >= key_q && (!b_q || cur_key < bkey_q);
  wire        scan     = st_q == mat_pkg::ST_FRM || st_q == mat_pkg::ST_STAT ||
                         st_q == mat_pkg::ST_NEXT;
  wire [1:0]  fmode    = mode_of(emode, fport_q);
  wire        sec_drop = fmode == mat_pkg::MAT_SECURE && !(m_q && msta_q);
  wire        learn    = !m_q && fmode == mat_pkg::MAT_AUTO && f_q;
  wire        can_stat = scnt_q < `MAT_STAT_MAX;
  wire        del_ok   = cmd_q[`MAT_CMD_DEL] && m_q && msta_q;
  wire        add_ok   = !cmd_q[`MAT_CMD_DEL] && (m_q ? (msta_q || can_stat) : (f_q && can_stat));
  wire        idle     = st_q == mat_pkg::ST_IDLE;
  wire        busy     = !idle || flush_p_q || cmd_p_q || age_p_q;
  wire        tick     = tick_q == 32'(TICK_CYCLES - 1);

  // APB decode; zero wait states, unmapped or misaligned addresses error
  wire wr       = psel && penable && pwrite;
  wire a_ok     = paddr[1:0] == 2'h0 && paddr <= `MAT_SCNT;
  wire w_ctrl   = wr && paddr == `MAT_CTRL;
  wire w_mode   = wr && paddr == `MAT_MODE;
  wire w_cmd    = wr && paddr == `MAT_CMD && |pwdata[2:0];
  wire w_flush  = w_ctrl && pwdata[`MAT_CTRL_FLUSH];
  wire go_flush = idle && flush_p_q;
  wire go_cmd   = idle && !flush_p_q && cmd_p_q;
  // A tick still pending when aging is switched off must not start a scan
  wire go_age   = idle && !flush_p_q && !cmd_p_q && age_p_q && !ageoff_q;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !a_ok;
  assign prdata    = prdata_q;
  assign frm_ready = idle && !flush_p_q && !cmd_p_q && !age_p_q;
  assign fwd_valid = fv_q;
  assign fwd_hit   = fh_q;
  assign fwd_drop  = fd_q;
  assign fwd_ports = fp_q;

  // Read mux, sampled in the setup phase so data is stable at access
  always_comb begin
    unique case (paddr)
      `MAT_CTRL:  rdv = {31'h00000000, ageoff_q};
      `MAT_AGE:   rdv = {8'h00, agetime_q};
      `MAT_MODE:  rdv = 32'(emode);
      `MAT_KVLAN: rdv = {20'h00000, kvlan_q};
      `MAT_KMACL: rdv = kmac_q[31:0];
      `MAT_KMACH: rdv = {16'h0000, kmac_q[47:32]};
      `MAT_KPORT: rdv = 32'(kport_q);
      `MAT_STAT:  rdv = {28'h0000000, err_q, rsta_q, eot_q, busy};
      `MAT_RVLAN: rdv = {20'h00000, rvlan_q};
      `MAT_RMACL: rdv = rmac_q[31:0];
      `MAT_RMACH: rdv = {16'h0000, rmac_q[47:32]};
      `MAT_RPORT: rdv = 32'(rport_q);
      `MAT_SCNT:  rdv = {25'h0000000, scnt_q};
      default:    rdv = 32'h00000000;
    endcase
  end

  // Software registers; a pending flag's new request wins over its clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ageoff_q  <= 1'b0;
      agetime_q <= `MAT_AGE_RST;
      mode_q    <= '0;
      kvlan_q   <= 12'h000;
      kmac_q    <= 48'h000000000000;
      kport_q   <= '0;
      cmd_q     <= 3'h0;
      flush_p_q <= 1'b0;
      cmd_p_q   <= 1'b0;
      age_p_q   <= 1'b0;
      tick_q    <= 32'h00000000;
      prdata_q  <= 32'h00000000;
    end else begin
      if (psel && !penable && !pwrite) prdata_q <= rdv;
      if (w_ctrl) ageoff_q <= pwdata[`MAT_CTRL_AGEOFF];
      if (wr && paddr == `MAT_AGE && pwdata[23:0] >= `MAT_AGE_MIN &&
          pwdata[31:24] == 8'h00 && pwdata[23:0] <= `MAT_AGE_MAX) begin
        agetime_q <= pwdata[23:0];
      end
      for (int i = 0; i < NPORTS; i++) begin
        if (w_mode && !auth_own[i]) mode_q[2*i +: 2] <= pwdata[2*i +: 2];
      end
      if (wr && paddr == `MAT_KVLAN) kvlan_q <= pwdata[11:0];
      if (wr && paddr == `MAT_KMACL) kmac_q[31:0] <= pwdata;
      if (wr && paddr == `MAT_KMACH) kmac_q[47:32] <= pwdata[15:0];
      if (wr && paddr == `MAT_KPORT) kport_q <= pwdata[NPORTS-1:0];
      if (w_cmd) cmd_q <= pwdata[2:0];
      flush_p_q <= w_flush || (flush_p_q && !go_flush);
      cmd_p_q   <= w_cmd || (cmd_p_q && !go_cmd);
      // Turning aging off also drops a tick that has not started yet
      age_p_q   <= !ageoff_q && (tick || (age_p_q && !go_age));
      tick_q    <= tick ? 32'h00000000 : tick_q + 32'h00000001;
    end
  end

  // Table write port: one entry per cycle, chosen by the engine state
  always_comb begin
    we   = 1'b0;
    widx = idx_q;
    wv   = cur_v;
    ws   = cur_s;
    wvl  = vlan_m[idx_q];
    wmc  = mac_m[idx_q];
    wpt  = prt_m[idx_q];
    wag  = age_m[idx_q];
    unique case (st_q)
      mat_pkg::ST_AGE: if (cur_v && !cur_s) begin
        we  = 1'b1;
        wag = age_nx;
        wv  = age_nx < agetime_q;
      end
      mat_pkg::ST_FLUSH: if (cur_v && !cur_s) begin
        we = 1'b1;
        wv = 1'b0;
      end
      mat_pkg::ST_FRM_END: if ((m_q && !msta_q) || learn) begin
        // A hit refreshes and re-homes the station, a miss installs it
        we         = 1'b1;
        widx       = m_q ? midx_q : fidx_q;
        wv         = 1'b1;
        ws         = 1'b0;
        {wvl, wmc} = key_q;
        wpt        = onehot(fport_q);
        wag        = 24'h000000;
      end
      mat_pkg::ST_STAT_END: if (del_ok) begin
        we   = 1'b1;
        widx = midx_q;
        wv   = 1'b0;
      end else if (add_ok) begin
        we         = 1'b1;
        widx       = m_q ? midx_q : fidx_q;
        wv         = 1'b1;
        ws         = 1'b1;
        {wvl, wmc} = key_q;
        wpt        = kport_q;
        wag        = 24'h000000;
      end
      default: ;
    endcase
  end

  // Entry contents carry no reset; the valid flag guards them
  always_ff @(posedge pclk) begin
    if (we) begin
      vlan_m[widx] <= wvl;
      mac_m[widx]  <= wmc;
      prt_m[widx]  <= wpt;
      age_m[widx]  <= wag;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vld_q <= '0;
      sta_q <= '0;
    end else if (we) begin
      vld_q[widx] <= wv;
      sta_q[widx] <= ws;
    end
  end

  // Scan engine; every operation walks the whole table, trading speed for area
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= mat_pkg::ST_IDLE;
      idx_q   <= '0;
      {m_q, msta_q, d_q, f_q, b_q, bsta_q} <= 6'h00;
      midx_q  <= '0;
      fidx_q  <= '0;
      dprt_q  <= '0;
      bprt_q  <= '0;
      key_q   <= 60'h000000000000000;
      dkey_q  <= 60'h000000000000000;
      bkey_q  <= 60'h000000000000000;
      fport_q <= '0;
      {eot_q, rsta_q, err_q, fv_q, fh_q, fd_q} <= 6'h00;
      scnt_q  <= 7'h00;
      rvlan_q <= 12'h000;
      rmac_q  <= 48'h000000000000;
      rport_q <= '0;
      fp_q    <= '0;
    end else begin
      fv_q <= st_q == mat_pkg::ST_FRM_END;
      if (scan) begin
        if (eq_a && !m_q) {m_q, midx_q, msta_q} <= {1'b1, idx_q, cur_s};
        if (eq_d) {d_q, dprt_q} <= {1'b1, prt_m[idx_q]};
        if (!cur_v && !f_q) {f_q, fidx_q} <= {1'b1, idx_q};
        if (better) {b_q, bkey_q, bprt_q, bsta_q} <= {1'b1, cur_key, prt_m[idx_q], cur_s};
      end
      unique case (st_q)
        mat_pkg::ST_IDLE: begin
          idx_q <= '0;
          {m_q, d_q, f_q, b_q} <= 4'h0;
          if (go_flush) begin
            st_q <= mat_pkg::ST_FLUSH;
          end else if (go_cmd) begin
            key_q <= {kvlan_q, kmac_q};
            st_q  <= cmd_q[`MAT_CMD_NEXT] ? mat_pkg::ST_NEXT : mat_pkg::ST_STAT;
          end else if (go_age) begin
            st_q <= mat_pkg::ST_AGE;
          end else if (frm_valid) begin
            key_q   <= {frm_vlan, frame_source_address};
            dkey_q  <= {frm_vlan, frame_destination_address};
            fport_q <= frm_port;
            st_q    <= mat_pkg::ST_FRM;
          end
        end
        mat_pkg::ST_FRM, mat_pkg::ST_STAT, mat_pkg::ST_NEXT,
        mat_pkg::ST_AGE, mat_pkg::ST_FLUSH: begin
          idx_q <= idx_q + IW'(1);
          if (last) begin
            unique case (st_q)
              mat_pkg::ST_FRM:  st_q <= mat_pkg::ST_FRM_END;
              mat_pkg::ST_STAT: st_q <= mat_pkg::ST_STAT_END;
              mat_pkg::ST_NEXT: st_q <= mat_pkg::ST_NEXT_END;
              default:          st_q <= mat_pkg::ST_IDLE;
            endcase
          end
        end
        mat_pkg::ST_FRM_END: begin
          // Unknown destinations flood to every port but the ingress one
          fh_q <= d_q;
          fd_q <= sec_drop;
          fp_q <= sec_drop ? '0 : d_q ? dprt_q : ~onehot(fport_q);
          st_q <= mat_pkg::ST_IDLE;
        end
        mat_pkg::ST_STAT_END: begin
          err_q <= !(del_ok || add_ok);
          if (del_ok) scnt_q <= scnt_q - 7'h01;
          else if (add_ok && !(m_q && msta_q)) scnt_q <= scnt_q + 7'h01;
          st_q <= mat_pkg::ST_IDLE;
        end
        mat_pkg::ST_NEXT_END: begin
          eot_q <= !b_q;
          if (b_q) {rvlan_q, rmac_q, rport_q, rsta_q} <= {bkey_q, bprt_q, bsta_q};
          st_q <= mat_pkg::ST_IDLE;
        end
        default: st_q <= mat_pkg::ST_IDLE;
      endcase
    end
  end

  // Checks on the engine and the registers
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_age_rst; $rose(presetn) |-> agetime_q == `MAT_AGE_RST; endproperty
  a_age_rst: assert property (p_age_rst) else $error("aging time not 300 after reset");
  property p_age_rng; agetime_q >= `MAT_AGE_MIN && agetime_q <= `MAT_AGE_MAX; endproperty
  a_age_rng: assert property (p_age_rng) else $error("aging time out of range");
  property p_age_off; ageoff_q && idle |=> st_q != mat_pkg::ST_AGE; endproperty
  a_age_off: assert property (p_age_off) else $error("aging ran while off");
  property p_expire;
    st_q == mat_pkg::ST_AGE && cur_v && !cur_s && age_nx >= agetime_q |=> !vld_q[$past(idx_q)];
  endproperty
  a_expire: assert property (p_expire) else $error("expired entry kept");
  property p_own;
    w_mode |=> (mode_q & $past(omask)) == ($past(mode_q) & $past(omask));
  endproperty
  a_own: assert property (p_own) else $error("owned port mode changed");
  property p_scnt; scnt_q <= `MAT_STAT_MAX; endproperty
  a_scnt: assert property (p_scnt) else $error("too many static entries");
  property p_learn;
    st_q == mat_pkg::ST_FRM_END && learn |=> vld_q[$past(fidx_q)] && !sta_q[$past(fidx_q)];
  endproperty
  a_learn: assert property (p_learn) else $error("unknown source not learned");
  property p_nolearn;
    st_q == mat_pkg::ST_FRM_END && !m_q && fmode != mat_pkg::MAT_AUTO |-> !we;
  endproperty
  a_nolearn: assert property (p_nolearn) else $error("entry created without auto mode");
  property p_secure; st_q == mat_pkg::ST_FRM_END && sec_drop |=> fwd_valid && fwd_drop; endproperty
  a_secure: assert property (p_secure) else $error("secure frame not dropped");
  property p_flush;
    st_q == mat_pkg::ST_FLUSH && cur_v && cur_s |=> vld_q[$past(idx_q)] && sta_q[$past(idx_q)];
  endproperty
  a_flush: assert property (p_flush) else $error("flush touched static entry");
  property p_eot; st_q == mat_pkg::ST_NEXT_END && !b_q |=> eot_q; endproperty
  a_eot: assert property (p_eot) else $error("end of table not flagged");
  property p_fwd;
    st_q == mat_pkg::ST_FRM_END && d_q && !sec_drop |=> fwd_ports == $past(dprt_q);
  endproperty
  a_fwd: assert property (p_fwd) else $error("wrong destination ports");
  property p_refresh;
    st_q == mat_pkg::ST_FRM_END && m_q && !msta_q |=> age_m[$past(midx_q)] == 24'h000000;
  endproperty
  a_refresh: assert property (p_refresh) else $error("source hit did not restart age");

  c_fwd: cover property (fwd_valid && fwd_hit && !fwd_drop);
  c_flush: cover property (st_q == mat_pkg::ST_FLUSH && last);
  c_eot: cover property (st_q == mat_pkg::ST_NEXT_END && !b_q);
endmodule
`default_nettype wire

// [verif/mat_fwd_model.sv]
// Forwarding pipeline model: offers frame lookups and collects the results
`timescale 1ns/100ps
`default_nettype none
module mat_fwd_model #(
  parameter int NPORTS = 12,
  parameter int PW     = 4
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Lookup request
  output logic                   frm_valid,
  input  wire logic              frm_ready,
  output logic [PW-1:0]          frm_port,
  output logic [11:0]            frm_vlan,
  output logic [47:0]            frame_source_address,
  output logic [47:0]            frame_destination_address,
  // Lookup result
  input  wire logic              fwd_valid,
  input  wire logic              fwd_hit,
  input  wire logic              fwd_drop,
  input  wire logic [NPORTS-1:0] fwd_ports
);
  logic              got_hit;
  logic              got_drop;
  logic [NPORTS-1:0] got_ports;
  // Quiet request lines at time zero
  initial begin
    frm_valid = 1'b0;
    frm_port = '0;
    frm_vlan = '0;
    frame_source_address = '0;
    frame_destination_address = '0;
  end
  // One frame: hold until taken, then wait for its single result pulse
  task automatic send(input logic [PW-1:0] p, input logic [11:0] v,
                      input logic [47:0] sa, input logic [47:0] da);
    int n;
    n = 0;
    frm_valid <= 1'b1;
    frm_port <= p;
    frm_vlan <= v;
    frame_source_address <= sa;
    frame_destination_address <= da;
    do begin
      @(posedge pclk);
      n++;
    end while (frm_ready !== 1'b1 && n < 3000);
    // Released lines show the inverse so a stale key never looks valid
    frm_valid <= 1'b0;
    frm_port <= ~p;
    frm_vlan <= ~v;
    frame_source_address <= ~sa;
    frame_destination_address <= ~da;
    do begin
      @(posedge pclk);
      n++;
    end while (fwd_valid !== 1'b1 && n < 3000);
    got_hit = (n < 3000) ? fwd_hit : 1'bx;
    got_drop = fwd_drop;
    got_ports = fwd_ports;
  endtask
endmodule
`default_nettype wire

// [verif/test_mac_address_table_learning.sv]
// Self-checking bench of the MAC address table
`timescale 1ns/100ps
`default_nettype none
`include "mat_regs.svh"
module test_mac_address_table_learning;
  localparam int NP = 12;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, st, r;
  logic          frm_valid, frm_ready, fwd_valid, fwd_hit, fwd_drop, e;
  logic [3:0]    frm_port;
  logic [11:0]   frm_vlan, sp[3];
  logic [47:0]   sa, da, ma, z;
  logic [NP-1:0] fwd_ports, auth_own;
  logic [23:0]   auth_mode;
  logic [59:0]   kk[3];
  int            seed = 32'h9086aa7e;
  int            n_mismatch = 0;
  int            n_compared = 0;
  int            cyc = 0;
  // Design and frame-side model
  mat_table #(.DEPTH(16), .NPORTS(NP), .TICK_CYCLES(40)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid),
    .frm_ready(frm_ready), .frm_port(frm_port), .frm_vlan(frm_vlan),
    .frame_source_address(sa), .frame_destination_address(da), .fwd_valid(fwd_valid),
    .fwd_hit(fwd_hit), .fwd_drop(fwd_drop), .fwd_ports(fwd_ports), .auth_own(auth_own),
    .auth_mode(auth_mode));
  mat_fwd_model #(.NPORTS(NP), .PW(4)) u_fwd (.pclk(pclk), .presetn(presetn),
    .frm_valid(frm_valid), .frm_ready(frm_ready), .frm_port(frm_port), .frm_vlan(frm_vlan),
    .frame_source_address(sa), .frame_destination_address(da), .fwd_valid(fwd_valid),
    .fwd_hit(fwd_hit), .fwd_drop(fwd_drop), .fwd_ports(fwd_ports));
  // Clock of 40 ns
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Hang guard: far above the few thousand cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      test_done;
    end
  end
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic chk_fwd(input logic h, input logic d, input logic [NP-1:0] p);
    chk_reg("forward", {18'h0, h, d, p}, {18'h0, u_fwd.got_hit, u_fwd.got_drop, u_fwd.got_ports});
  endtask
  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_mismatch++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `MAT_STAT, '0);
      n++;
    end while (r[0] !== 1'b0 && n < 100);
    if (r[0] !== 1'b0) n_mismatch++;
    st = r;
  endtask
  task automatic cmd(input logic [59:0] k, input logic [11:0] p, input int b);
    apb(1'b1, `MAT_KVLAN, 32'(k[59:48]));
    apb(1'b1, `MAT_KMACL, k[31:0]);
    apb(1'b1, `MAT_KMACH, 32'(k[47:32]));
    apb(1'b1, `MAT_KPORT, 32'(p));
    apb(1'b1, `MAT_CMD, 32'h1 << b);
    wait_idle;
  endtask
  // Index of the smallest static key at or above k, or -1
  function automatic int next_idx(input logic [59:0] k);
    next_idx = -1;
    for (int j = 0; j < 3; j++)
      if (kk[j] >= k && (next_idx < 0 || kk[j] < kk[next_idx])) next_idx = j;
  endfunction
  function automatic logic [NP-1:0] flood(input int p);
    flood = ~(NP'(1) << p);
  endfunction
  task automatic gnext(input logic [59:0] k);
    int i;
    i = next_idx(k);
    cmd(k, '0, `MAT_CMD_NEXT);
    // On end of table the result registers keep the last (static) entry
    chk_reg("stat", (i < 0) ? 32'h6 : 32'h4, st & 32'h6);
    if (i >= 0) begin
      apb(1'b0, `MAT_RVLAN, '0);
      chk_reg("rvlan", 32'(kk[i][59:48]), r);
      apb(1'b0, `MAT_RMACL, '0);
      chk_reg("rmacl", kk[i][31:0], r);
      apb(1'b0, `MAT_RMACH, '0);
      chk_reg("rmach", 32'(kk[i][47:32]), r);
      apb(1'b0, `MAT_RPORT, '0);
      chk_reg("rport", 32'(sp[i]), r);
    end
  endtask
  // Main sequence
  initial begin
    logic [59:0] k;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    auth_own = '0;
    auth_mode = '0;
    z = 48'h02_0000_0000_99;
    ma = 48'h02_0000_0000_01;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `MAT_AGE, '0);
    chk_reg("age reset", 32'(`MAT_AGE_RST), r);
    apb(1'b1, `MAT_AGE, 32'd9);
    apb(1'b1, `MAT_AGE, 32'd10000001);
    apb(1'b0, `MAT_AGE, '0);
    chk_reg("age range", 32'(`MAT_AGE_RST), r);
    apb(1'b0, 8'h38, '0);
    chk_reg("unmapped", 32'h1, {r[30:0], e});
    // Three random static entries, then walk them in key order
    for (int j = 0; j < 3; j++) begin
      kk[j] = 60'({$random(seed), $random(seed)});
      sp[j] = 12'($random(seed)) | 12'h001;
      cmd(kk[j], sp[j], `MAT_CMD_ADD);
      chk_reg("add err", 32'h0, st & 32'h8);
    end
    apb(1'b0, `MAT_SCNT, '0);
    chk_reg("static count", 32'd3, r);
    gnext(kk[1]);
    k = '0;
    for (int j = 0; j < 4; j++) begin
      gnext(k);
      if (next_idx(k) >= 0) k = kk[next_idx(k)] + 60'h1;
    end
    u_fwd.send(4'd0, kk[0][59:48], z, kk[0][47:0]);
    chk_fwd(1'b1, 1'b0, sp[0]);
    // Auto learning, then the dynamic entry seen by lookup and get-next
    u_fwd.send(4'd3, 12'h005, ma, z + 48'h1);
    u_fwd.send(4'd5, 12'h005, z + 48'h2, ma);
    chk_fwd(1'b1, 1'b0, NP'(1) << 3);
    cmd({12'h005, ma}, '0, `MAT_CMD_NEXT);
    chk_reg("dyn type", 32'h0, st & 32'h6);
    // Port 4 learning off, port 6 secure
    apb(1'b1, `MAT_MODE, (32'h1 << 8) | (32'h2 << 12));
    u_fwd.send(4'd4, 12'h005, z + 48'h3, ma);
    u_fwd.send(4'd2, 12'h005, z, z + 48'h3);
    chk_fwd(1'b0, 1'b0, flood(2));
    u_fwd.send(4'd6, 12'h005, z + 48'h4, ma);
    chk_fwd(1'b1, 1'b1, '0);
    u_fwd.send(4'd6, kk[1][59:48], kk[1][47:0], ma);
    chk_fwd(1'b0, 1'b0, flood(6));
    // Port 7 owned by another function in disabled mode
    auth_own <= NP'(1) << 7;
    auth_mode <= 24'h1 << 14;
    apb(1'b1, `MAT_MODE, (32'h1 << 8) | (32'h2 << 12) | (32'h2 << 14));
    apb(1'b0, `MAT_MODE, '0);
    chk_reg("owned mode", (32'h1 << 8) | (32'h2 << 12) | (32'h1 << 14), r);
    u_fwd.send(4'd7, 12'h005, z + 48'h5, ma);
    u_fwd.send(4'd2, 12'h005, z, z + 48'h5);
    chk_fwd(1'b0, 1'b0, flood(2));
    auth_own <= '0;
    apb(1'b0, `MAT_MODE, '0);
    chk_reg("mode kept", (32'h1 << 8) | (32'h2 << 12), r);
    // Aging at 10 s: refreshed entry survives 16 s, then expires
    apb(1'b1, `MAT_AGE, 32'd10);
    for (int j = 0; j < 4; j++) begin
      repeat (160) @(posedge pclk);
      u_fwd.send(4'd3, 12'h005, ma, z + 48'h1);
    end
    u_fwd.send(4'd1, 12'h005, z, ma);
    chk_fwd(1'b1, 1'b0, NP'(1) << 3);
    repeat (560) @(posedge pclk);
    u_fwd.send(4'd1, 12'h005, z, ma);
    chk_fwd(1'b0, 1'b0, flood(1));
    apb(1'b1, `MAT_CTRL, 32'h1);
    u_fwd.send(4'd3, 12'h005, ma, z + 48'h1);
    repeat (560) @(posedge pclk);
    u_fwd.send(4'd1, 12'h005, z, ma);
    chk_fwd(1'b1, 1'b0, NP'(1) << 3);
    // Flush keeps static entries only
    apb(1'b1, `MAT_CTRL, 32'h3);
    wait_idle;
    u_fwd.send(4'd1, 12'h005, z, ma);
    chk_fwd(1'b0, 1'b0, flood(1));
    u_fwd.send(4'd1, kk[0][59:48], z, kk[0][47:0]);
    chk_fwd(1'b1, 1'b0, sp[0]);
    // Delete a static entry, then delete it again
    cmd(kk[2], '0, `MAT_CMD_DEL);
    apb(1'b0, `MAT_SCNT, '0);
    chk_reg("count after del", 32'd2, r);
    cmd(kk[2], '0, `MAT_CMD_DEL);
    chk_reg("del err", 32'h8, st & 32'h8);
    test_done;
  end
endmodule
`default_nettype wire
